// [core/dpr_regs.vh]
// Constants for the dual-port bit array and its APB register file.
// Functional notes
// - Two independent ports read and write one shared array of 4096 bits.
// - Each port width is 1, 2, 4, 8 or 16 bits, with the depth and address width to match.
// - Each port samples its inputs and updates its output only on an edge of its own clock.
// - With enable inactive at an edge a port does no read, write or reset, and its output holds.
// - An enabled edge with write enable active stores the input word and shows it on the output, or zero if port reset is also active.
// - An enabled edge with write enable inactive loads the addressed word onto the output.
// - Port reset clears that port's output register to zero and leaves the array untouched.
// - Reset on one port never disturbs a write made by the other port.
// - The output is registered and holds the word of the last active edge.
// - Clock, enable, write enable and reset of each port each have their own inversion option.
// - Word a of a w-bit port occupies array bits a*w to a*w+w-1 on both ports.
`ifndef DPR_REGS_VH
`define DPR_REGS_VH

// ==========================================================
// Array geometry
// ==========================================================
`define DPR_ARRAY_BITS     4096
`define DPR_ARRAY_AW       12
`define DPR_MAX_WIDTH      16

// ==========================================================
// Register offsets (byte addresses)
// ==========================================================
`define DPR_APB_AW         4
`define DPR_OFS_POLARITY   4'h0
`define DPR_OFS_WRCOUNT    4'h4
`define DPR_OFS_OUTA       4'h8
`define DPR_OFS_OUTB       4'hc

// ==========================================================
// Polarity register fields, reset value
// ==========================================================
`define DPR_POL_CLKA       0
`define DPR_POL_ENA        1
`define DPR_POL_WEA        2
`define DPR_POL_RSTA       3
`define DPR_POL_CLKB       4
`define DPR_POL_ENB        5
`define DPR_POL_WEB        6
`define DPR_POL_RSTB       7
`define DPR_POL_BITS       8
`define DPR_POL_RESET      8'h00

// ==========================================================
// Write counter fields
// ==========================================================
`define DPR_CNT_BITS       16
`define DPR_CNT_A_LSB      0
`define DPR_CNT_B_LSB      16

`endif

// [core/dpr_bit_array.v]
// Shared 4096-bit array with two width-configurable registered ports.
`timescale 1ns/1ps
`include "dpr_regs.vh"

module dpr_bit_array #(
	parameter WIDTH_A = 16,
	parameter WIDTH_B = 16,
	parameter AW_A    = 8,
	parameter AW_B    = 8
) (
	input  wire               clk_sys,
	input  wire               reset_n,
	input  wire               strobeA,
	input  wire               writeA,
	input  wire               clearA,
	input  wire [AW_A-1:0]    addrA,
	input  wire [WIDTH_A-1:0] writeDataInA,
	output reg  [WIDTH_A-1:0] readDataOutA,
	input  wire               strobeB,
	input  wire               writeB,
	input  wire               clearB,
	input  wire [AW_B-1:0]    addrB,
	input  wire [WIDTH_B-1:0] writeDataInB,
	output reg  [WIDTH_B-1:0] readDataOutB
);

	reg mem [0:`DPR_ARRAY_BITS-1];
	integer i;
	integer j;
	integer k;
	integer m;

	// ==========================================================
	// Array writes, both ports in one process
	// ==========================================================
	// Colliding bits end with port B's value; user logic must avoid it
	always @(posedge clk_sys) begin
		if (strobeA && writeA) begin
			for (i = 0; i < WIDTH_A; i = i + 1)
				mem[addrA * WIDTH_A + i] <= writeDataInA[i];
		end
		// A reset on port A leaves this write alone
		if (strobeB && writeB) begin
			for (j = 0; j < WIDTH_B; j = j + 1)
				mem[addrB * WIDTH_B + j] <= writeDataInB[j];
		end
	end

	// ==========================================================
	// Port A output register
	// ==========================================================
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			readDataOutA <= {WIDTH_A{1'b0}};
		end else if (strobeA) begin
			if (clearA) begin
				readDataOutA <= {WIDTH_A{1'b0}};
			end else if (writeA) begin
				readDataOutA <= writeDataInA;
			end else begin
				for (k = 0; k < WIDTH_A; k = k + 1)
					readDataOutA[k] <= mem[addrA * WIDTH_A + k];
			end
		end
	end

	// ==========================================================
	// Port B output register
	// ==========================================================
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			readDataOutB <= {WIDTH_B{1'b0}};
		end else if (strobeB) begin
			if (clearB) begin
				readDataOutB <= {WIDTH_B{1'b0}};
			end else if (writeB) begin
				readDataOutB <= writeDataInB;
			end else begin
				for (m = 0; m < WIDTH_B; m = m + 1)
					readDataOutB[m] <= mem[addrB * WIDTH_B + m];
			end
		end
	end

endmodule // dpr_bit_array

// [core/dpr_ram_top.v]
// Dual-port block RAM: port clock edge detection, polarity and APB registers.
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
`include "dpr_regs.vh"

module dpr_ram_top #(
	parameter WIDTH_A = 16,
	parameter WIDTH_B = 16
) (
	input  wire                       clk_sys,
	input  wire                       reset_n,
	// APB slave
	input  wire                       psel,
	input  wire                       penable,
	input  wire                       pwrite,
	input  wire [31:0]                paddr,
	input  wire [31:0]                pwdata,
	output reg  [31:0]                prdata,
	output wire                       pready,
	output reg                        pslverr,
	// Port A
	input  wire                       portClkA,
	input  wire                       portEnA,
	input  wire                       portWeA,
	input  wire                       portRstA,
	input  wire [dpr_aw(WIDTH_A)-1:0] portAddrA,
	input  wire [WIDTH_A-1:0]         writeDataInA,
	output wire [WIDTH_A-1:0]         readDataOutA,
	// Port B
	input  wire                       portClkB,
	input  wire                       portEnB,
	input  wire                       portWeB,
	input  wire                       portRstB,
	input  wire [dpr_aw(WIDTH_B)-1:0] portAddrB,
	input  wire [WIDTH_B-1:0]         writeDataInB,
	output wire [WIDTH_B-1:0]         readDataOutB
);

	// ==========================================================
	// Geometry helpers
	// ==========================================================
	// Address width for a port width: 12 bits at width 1, 8 at width 16
	function integer dpr_aw;
		input integer width;
		integer n;
		begin
			n = 0;
			while ((1 << n) < width)
				n = n + 1;
			dpr_aw = `DPR_ARRAY_AW - n;
		end
	endfunction

	// Only power-of-two widths up to 16 are legal
	function legal_width;
		input integer width;
		begin
			legal_width = (width == 1) || (width == 2) || (width == 4) ||
				(width == 8) || (width == 16);
		end
	endfunction

	localparam AW_A    = dpr_aw(WIDTH_A);
	localparam AW_B    = dpr_aw(WIDTH_B);
	localparam WIDTHOK = legal_width(WIDTH_A) && legal_width(WIDTH_B);

	// ==========================================================
	// Polarity register
	// ==========================================================
	reg  [`DPR_POL_BITS-1:0] polarity;
	reg  [`DPR_CNT_BITS-1:0] writeCountA;
	reg  [`DPR_CNT_BITS-1:0] writeCountB;

	wire [`DPR_APB_AW-1:0] regAddr;
	wire                   apbAccess;
	wire                   apbWrite;
	wire                   apbRead;
	wire                   addrHit;
	wire                   addrWritable;

	assign regAddr      = paddr[`DPR_APB_AW-1:0];
	assign pready       = 1'b1;
	assign apbAccess    = psel && penable;
	assign apbWrite     = apbAccess && pwrite;
	assign apbRead      = apbAccess && !pwrite;
	// Upper address bits must be zero, else the access is unmapped
	assign addrHit      = (paddr[31:`DPR_APB_AW] == 28'h0000000) &&
		((regAddr == `DPR_OFS_POLARITY) || (regAddr == `DPR_OFS_WRCOUNT) ||
		(regAddr == `DPR_OFS_OUTA) || (regAddr == `DPR_OFS_OUTB));
	assign addrWritable = addrHit && (regAddr == `DPR_OFS_POLARITY);

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			polarity <= `DPR_POL_RESET;
		end else if (apbWrite && addrWritable) begin
			// Meant to be set once before the ports are used
			polarity <= pwdata[`DPR_POL_BITS-1:0];
		end
	end

	// ==========================================================
	// Port control decode with polarity
	// ==========================================================
	wire effClkA;
	wire effClkB;
	wire effEnA;
	wire effEnB;
	wire effWeA;
	wire effWeB;
	wire effRstA;
	wire effRstB;

	assign effClkA = portClkA ^ polarity[`DPR_POL_CLKA];
	assign effClkB = portClkB ^ polarity[`DPR_POL_CLKB];
	assign effEnA  = portEnA  ^ polarity[`DPR_POL_ENA];
	assign effEnB  = portEnB  ^ polarity[`DPR_POL_ENB];
	assign effWeA  = portWeA  ^ polarity[`DPR_POL_WEA];
	assign effWeB  = portWeB  ^ polarity[`DPR_POL_WEB];
	assign effRstA = portRstA ^ polarity[`DPR_POL_RSTA];
	assign effRstB = portRstB ^ polarity[`DPR_POL_RSTB];

	// ==========================================================
	// Port clock edge detection
	// ==========================================================
	// Port clocks are sampled on clk_sys; each port must run well below
	// half of clk_sys. Changing a clock inversion bit can fake one edge.
	reg  lastClkA;
	reg  lastClkB;
	wire edgeA;
	wire edgeB;
	wire strobeA;
	wire strobeB;

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			lastClkA <= 1'b0;
			lastClkB <= 1'b0;
		end else begin
			lastClkA <= effClkA;
			lastClkB <= effClkB;
		end
	end

	// Each port acts only on its own clock edge
	assign edgeA   = effClkA && !lastClkA;
	assign edgeB   = effClkB && !lastClkB;
	// Independent strobes, no arbitration between ports
	assign strobeA = edgeA && effEnA && WIDTHOK;
	assign strobeB = edgeB && effEnB && WIDTHOK;

	// ==========================================================
	// Write activity counters
	// ==========================================================
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			writeCountA <= 16'h0000;
			writeCountB <= 16'h0000;
		end else begin
			if (strobeA && effWeA)
				writeCountA <= writeCountA + 16'h0001;
			if (strobeB && effWeB)
				writeCountB <= writeCountB + 16'h0001;
		end
	end

	// ==========================================================
	// APB read data and error
	// ==========================================================
	reg [31:0] next_prdata;

	always @* begin
		next_prdata = 32'h00000000;
		case (regAddr)
			`DPR_OFS_POLARITY: next_prdata[`DPR_POL_BITS-1:0] = polarity;
			`DPR_OFS_WRCOUNT: begin
				next_prdata[`DPR_CNT_A_LSB +: `DPR_CNT_BITS] = writeCountA;
				next_prdata[`DPR_CNT_B_LSB +: `DPR_CNT_BITS] = writeCountB;
			end
			`DPR_OFS_OUTA: next_prdata[WIDTH_A-1:0] = readDataOutA;
			`DPR_OFS_OUTB: next_prdata[WIDTH_B-1:0] = readDataOutB;
			default: next_prdata = 32'h00000000;
		endcase
		if (!addrHit)
			next_prdata = 32'h00000000;
	end

	// Registered in the setup cycle so data is stable in the access phase
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= next_prdata;
		end
	end

	// Error for unmapped addresses and writes to read-only registers
	always @* begin
		pslverr = 1'b0;
		if (apbAccess) begin
			if (apbRead)
				pslverr = !addrHit;
			else
				pslverr = !addrWritable;
		end
	end

	// ==========================================================
	// Shared bit array
	// ==========================================================
	dpr_bit_array #(
		.WIDTH_A (WIDTH_A),
		.WIDTH_B (WIDTH_B),
		.AW_A    (AW_A),
		.AW_B    (AW_B)
	) u_array (
		.clk_sys      (clk_sys),
		.reset_n      (reset_n),
		.strobeA      (strobeA),
		.writeA       (effWeA),
		.clearA       (effRstA),
		.addrA        (portAddrA),
		.writeDataInA (writeDataInA),
		.readDataOutA (readDataOutA),
		.strobeB      (strobeB),
		.writeB       (effWeB),
		.clearB       (effRstB),
		.addrB        (portAddrB),
		.writeDataInB (writeDataInB),
		.readDataOutB (readDataOutB)
	);

endmodule // dpr_ram_top

// [verif/dpr_ram_sva.sv]
// Checker for the port outputs and register reads of the dual-port RAM.
`timescale 1ns/1ps
module dpr_ram_sva #(
	parameter WIDTH_A = 16,
	parameter WIDTH_B = 16
) (
	input logic               clk_sys,
	input logic               reset_n,
	input logic               psel,
	input logic               penable,
	input logic               pwrite,
	input logic [31:0]        paddr,
	input logic [31:0]        pwdata,
	input logic [31:0]        prdata,
	input logic               portClkA,
	input logic               portEnA,
	input logic               portWeA,
	input logic               portRstA,
	input logic [WIDTH_A-1:0] writeDataInA,
	input logic [WIDTH_A-1:0] readDataOutA,
	input logic               portClkB,
	input logic               portEnB,
	input logic               portWeB,
	input logic               portRstB,
	input logic [WIDTH_B-1:0] writeDataInB,
	input logic [WIDTH_B-1:0] readDataOutB
);
	// ==========================================
	// Shadow of the polarity bits and port edges
	// ==========================================
	logic [7:0] pol;
	logic       lastA;
	logic       lastB;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pol <= 8'h00;
			lastA <= 1'h0;
			lastB <= 1'h0;
		end else begin
			if (psel && penable && pwrite && paddr == 32'h0)
				pol <= pwdata[7:0];
			lastA <= portClkA ^ pol[0];
			lastB <= portClkB ^ pol[4];
		end
	end
	wire hitA = (portClkA ^ pol[0]) && !lastA && (portEnA ^ pol[1]);
	wire hitB = (portClkB ^ pol[4]) && !lastB && (portEnB ^ pol[5]);
	wire rsA  = portRstA ^ pol[3];
	wire rsB  = portRstB ^ pol[7];
	// ==========================================
	// Assertions
	// ==========================================
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence s_wrA;
		hitA && (portWeA ^ pol[2]) && !rsA;
	endsequence
	sequence s_wrB;
		hitB && (portWeB ^ pol[6]) && !rsB;
	endsequence
	AST_HOLD_A: assert property (
		!hitA |=> $stable(readDataOutA))
		else $error("port A output moved without an enabled edge");
	AST_HOLD_B: assert property (
		!hitB |=> $stable(readDataOutB))
		else $error("port B output moved without an enabled edge");
	AST_ONLY_EDGE_A: assert property (
		$changed(readDataOutA) |-> $past(hitA))
		else $error("port A output changed off its own edge");
	AST_ONLY_EDGE_B: assert property (
		$changed(readDataOutB) |-> $past(hitB))
		else $error("port B output changed off its own edge");
	AST_WRITE_A: assert property (
		s_wrA |=> readDataOutA == $past(writeDataInA))
		else $error("port A write data not shown on output");
	AST_WRITE_B: assert property (
		s_wrB |=> readDataOutB == $past(writeDataInB))
		else $error("port B write data not shown on output");
	AST_RST_A: assert property (
		hitA && rsA |=> readDataOutA == '0)
		else $error("port A output not cleared by reset");
	AST_RST_B: assert property (
		hitB && rsB |=> readDataOutB == '0)
		else $error("port B output not cleared by reset");
	AST_OUTA_REG: assert property (
		psel && !penable && !pwrite && paddr == 32'h8 |=>
		prdata == {{(32-WIDTH_A){1'h0}}, $past(readDataOutA)})
		else $error("port A output register read back wrong");
	AST_OUTB_REG: assert property (
		psel && !penable && !pwrite && paddr == 32'hc |=>
		prdata == {{(32-WIDTH_B){1'h0}}, $past(readDataOutB)})
		else $error("port B output register read back wrong");
endmodule // dpr_ram_sva

// [verif/dpr_port_user.sv]
// User logic model driving one memory port with single clock pulses.
`timescale 1ns/1ps
module dpr_port_user #(
	parameter W  = 16,
	parameter AW = 8
) (
	input  logic          clk_sys,
	output logic          portClk,
	output logic          portEn,
	output logic          portWe,
	output logic          portRst,
	output logic [AW-1:0] portAddr,
	output logic [W-1:0]  writeData
);
	initial begin
		portClk = 1'h0;
		portEn = 1'h0;
		portWe = 1'h0;
		portRst = 1'h0;
		portAddr = '0;
		writeData = '0;
	end
	// Bench serialises colliding accesses; afterwards address and data turn over
	task automatic access(input logic e, w, r, input logic [AW-1:0] a,
		input logic [W-1:0] d);
		@(posedge clk_sys);
		portEn <= e;
		portWe <= w;
		portRst <= r;
		portAddr <= a;
		writeData <= d;
		@(posedge clk_sys);
		portClk <= 1'h1;
		@(posedge clk_sys);
		portClk <= 1'h0;
		@(posedge clk_sys);
		portAddr <= ~a;
		writeData <= ~d;
	endtask
endmodule // dpr_port_user

// [verif/dpr_ram_top_tb_top.sv]
// Testbench for the dual-port RAM: APB register access and both ports.
`timescale 1ns/1ps
module dpr_ram_top_tb_top;
	logic clk_sys, reset_n, psel, penable, pwrite, er;
	logic [31:0] paddr, pwdata, rd;
	wire [31:0] prdata;
	wire pready, pslverr, ckA, enA, weA, rsA, ckB, enB, weB, rsB;
	wire [7:0] adA;
	wire [9:0] adB;
	wire [15:0] wdA, rdA;
	wire [3:0] wdB, rdB;
	int num_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	dpr_ram_top #(.WIDTH_A(16), .WIDTH_B(4)) dut (.clk_sys(clk_sys),
		.reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .portClkA(ckA), .portEnA(enA), .portWeA(weA),
		.portRstA(rsA), .portAddrA(adA), .writeDataInA(wdA),
		.readDataOutA(rdA), .portClkB(ckB), .portEnB(enB), .portWeB(weB),
		.portRstB(rsB), .portAddrB(adB), .writeDataInB(wdB),
		.readDataOutB(rdB));
	// Port A model runs at its default width of 16
	dpr_port_user ua (.clk_sys(clk_sys), .portClk(ckA),
		.portEn(enA), .portWe(weA), .portRst(rsA), .portAddr(adA),
		.writeData(wdA));
	dpr_port_user #(.W(4), .AW(10)) ub (.clk_sys(clk_sys), .portClk(ckB),
		.portEn(enB), .portWe(weB), .portRst(rsB), .portAddr(adB),
		.writeData(wdB));
	// ==========================================
	// Tasks
	// ==========================================
	task automatic check(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, d);
		@(posedge clk_sys);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		do @(posedge clk_sys); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ==========================================
	// Clock, watchdog, tests
	// ==========================================
	initial begin
		clk_sys = 1'h0;
		forever #25 clk_sys = ~clk_sys;
	end
	// Whole run needs about a hundred cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			finish_test();
		end
	end
	initial begin
		reset_n = 1'h0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (6) @(posedge clk_sys);
		reset_n <= 1'h1;
		apb(1'h0, 32'h0, 32'h0);
		check("pol reset", rd, 32'h0);
		apb(1'h0, 32'h10, 32'h0);
		check("unmapped err", {31'h0, er}, 32'h1);
		apb(1'h1, 32'h4, 32'hff);
		check("ro write err", {31'h0, er}, 32'h1);
		$display("test registers done");
		ua.access(1'h1, 1'h1, 1'h0, 8'h5, 16'hbeef);
		check("rdA write", rdA, 32'hbeef);
		for (int i = 0; i < 4; i++) begin
			ub.access(1'h1, 1'h0, 1'h0, 10'h14 + i[9:0], 4'h0);
			check("rdB read", rdB, (32'hbeef >> (4 * i)) & 32'hf);
		end
		ub.access(1'h1, 1'h1, 1'h0, 10'h15, 4'h3);
		check("rdB write", rdB, 32'h3);
		// Disabled port B must neither write bits 88..91 nor clear its output
		ub.access(1'h0, 1'h1, 1'h1, 10'h16, 4'h9);
		check("rdB disabled", rdB, 32'h3);
		apb(1'h0, 32'hc, 32'h0);
		check("outB reg", rd, 32'h3);
		ua.access(1'h1, 1'h0, 1'h0, 8'h5, 16'h0);
		check("rdA read", rdA, 32'hbe3f);
		ua.access(1'h0, 1'h1, 1'h1, 8'h5, 16'h0);
		check("rdA disabled", rdA, 32'hbe3f);
		ua.access(1'h1, 1'h0, 1'h0, 8'h5, 16'h0);
		check("rdA no write", rdA, 32'hbe3f);
		apb(1'h0, 32'h8, 32'h0);
		check("outA reg", rd, 32'hbe3f);
		$display("test ports done");
		fork
			ua.access(1'h1, 1'h1, 1'h0, 8'h7, 16'h5555);
			ub.access(1'h1, 1'h0, 1'h1, 10'h0, 4'h0);
		join
		check("rdB reset", rdB, 32'h0);
		ua.access(1'h1, 1'h0, 1'h0, 8'h7, 16'h0);
		check("rdA other write", rdA, 32'h5555);
		ua.access(1'h1, 1'h0, 1'h1, 8'h5, 16'h0);
		check("rdA reset", rdA, 32'h0);
		ua.access(1'h1, 1'h0, 1'h0, 8'h5, 16'h0);
		check("array kept", rdA, 32'hbe3f);
		// Two enabled writes on A, one on B; disabled ones do not count
		apb(1'h0, 32'h4, 32'h0);
		check("write counts", rd, 32'h00010002);
		$display("test resets done");
		apb(1'h1, 32'h0, 32'he);
		apb(1'h0, 32'h0, 32'h0);
		check("pol rw", rd, 32'he);
		ua.access(1'h0, 1'h1, 1'h1, 8'h7, 16'h0);
		check("rdA inverted", rdA, 32'h5555);
		apb(1'h1, 32'h0, 32'h0);
		$display("test inversion done");
		finish_test();
	end
endmodule // dpr_ram_top_tb_top

bind dpr_ram_top dpr_ram_sva #(.WIDTH_A(WIDTH_A), .WIDTH_B(WIDTH_B)) chk (
	.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.portClkA(portClkA), .portEnA(portEnA), .portWeA(portWeA),
	.portRstA(portRstA), .writeDataInA(writeDataInA),
	.readDataOutA(readDataOutA), .portClkB(portClkB), .portEnB(portEnB),
	.portWeB(portWeB), .portRstB(portRstB), .writeDataInB(writeDataInB),
	.readDataOutB(readDataOutB));
